// ---- hdl/smr_pkg.sv ----
package smr_pkg;

	// ------------------------------------------------------------
	// Slave byte
	// ------------------------------------------------------------
	localparam logic [3:0] SMR_ID_ARRAY    = 4'hA;
	localparam logic [3:0] SMR_ID_CLOCK    = 4'hD;
	localparam logic [2:0] SMR_SELECT      = 3'h7;
	localparam int         SMR_ID_POS      = 4;
	localparam int         SMR_SELECT_POS  = 1;
	localparam int         SMR_RW_POS      = 0;

	// ------------------------------------------------------------
	// Address counter and byte framing
	// ------------------------------------------------------------
	localparam int          SMR_ADDR_W      = 16;
	localparam logic [15:0] SMR_ADDR_RST    = 16'h0000;
	localparam logic [15:0] SMR_ADDR_STEP   = 16'h0001;
	localparam logic [2:0]  SMR_LAST_BIT    = 3'h7;
	localparam logic [3:0]  SMR_ACK_BIT     = 4'h8;
	localparam logic [1:0]  SMR_WADDR_BYTES = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         SMR_CLK_NS       = 50;
	localparam int         SMR_SCL_HALF_NS  = 200;
	localparam int         SMR_HALF_RAW     = SMR_SCL_HALF_NS / SMR_CLK_NS;
	localparam logic [2:0] SMR_SCL_HALF_CYC =
		3'(SMR_HALF_RAW < 1 ? 1 : SMR_HALF_RAW);

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	localparam int SMR_FIFO_W = 8;
	localparam int SMR_FIFO_D = 8;

	// ------------------------------------------------------------
	// Host commands
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SMR_CUR_READ,
		SMR_RAND_READ,
		SMR_SET_ADDR
	} smr_cmd_e;

	function automatic logic [7:0] smr_slave_byte(input logic space,
		input logic rd);
		smr_slave_byte = {(space ? SMR_ID_CLOCK : SMR_ID_ARRAY),
			SMR_SELECT, rd};
	endfunction

	function automatic logic smr_id_match(input logic [7:0] b);
		smr_id_match = (b[7:SMR_ID_POS] == SMR_ID_ARRAY ||
			b[7:SMR_ID_POS] == SMR_ID_CLOCK) &&
			b[SMR_ID_POS-1:SMR_SELECT_POS] == SMR_SELECT;
	endfunction

endpackage

// ---- hdl/smr_if.sv ----
`timescale 1ns/1ns
interface smr_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired-and with pull-ups
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) ||
		(dev_sda_oe && !dev_sda_o));

	modport host (output host_scl_o, host_scl_oe, host_sda_o,
		host_sda_oe, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ---- hdl/smr_dev.sv ----
`timescale 1ns/1ns

// ------------------------------------------------------------
// Buffer
// ------------------------------------------------------------
module smr_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} smr_fifo_s;

	smr_fifo_s q;
	smr_fifo_s d;
	logic      full;
	logic      empty;

	assign full      = q.wp == {~q.rp[AW], q.rp[AW-1:0]};
	assign empty     = q.wp == q.rp;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = q.mem[q.rp[AW-1:0]];

	always_comb begin
		d = q;
		if (in_valid && !full) begin
			d.mem[q.wp[AW-1:0]] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			d.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end
endmodule // smr_fifo

// ------------------------------------------------------------
// Device end
// ------------------------------------------------------------
module smr_dev
	import smr_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// Serial link
	smr_if.dev               link,
	// Memory read port
	output logic [15:0]      mem_addr,
	output logic             mem_space,
	input  wire logic [7:0]  mem_rdata,
	// Status
	output logic             busy
);
	typedef enum logic [2:0] {
		D_IDLE,
		D_SLAVE,
		D_ACK,
		D_WADDR,
		D_TX,
		D_RACK
	} smr_dst_e;

	typedef struct packed {
		logic        scl_m;
		logic        scl_s;
		logic        scl_p;
		logic        sda_m;
		logic        sda_s;
		logic        sda_p;
		smr_dst_e    dst;
		logic [2:0]  cnt;
		logic        full;
		logic [7:0]  sh;
		logic        rd;
		logic        space;
		logic        mack;
		logic        sda_oe;
		logic [15:0] addr;
		logic [15:0] wa;
		logic [1:0]  wa_n;
	} smr_dev_s;

	smr_dev_s q;
	smr_dev_s d;
	logic     rise;
	logic     fall;
	logic     start;
	logic     stop;
	logic     load;

	assign rise  = q.scl_s && !q.scl_p;
	assign fall  = !q.scl_s && q.scl_p;
	assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
	assign stop  = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

	always_comb begin
		d = q;
		load = 1'b0;
		// Two-stage synchronisers and edge history
		d.scl_m = link.scl;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = link.sda;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		if (start || stop) begin
			// Pending address lands on stop or repeated start
			if (q.wa_n == SMR_WADDR_BYTES) begin
				d.addr = q.wa;
			end
			d.wa_n   = '0;
			d.sda_oe = 1'b0;
			d.cnt    = '0;
			d.full   = 1'b0;
			d.dst    = start ? D_SLAVE : D_IDLE;
		end else begin
			unique case (q.dst)
			D_IDLE: begin
			end
			D_SLAVE, D_WADDR: begin
				if (rise && !q.full) begin
					d.sh   = {q.sh[6:0], q.sda_s};
					d.cnt  = q.cnt + 3'h1;
					d.full = q.cnt == SMR_LAST_BIT;
				end
				if (fall && q.full) begin
					d.full = 1'b0;
					d.cnt  = '0;
					if (q.dst == D_SLAVE) begin
						if (smr_id_match(q.sh)) begin
							d.sda_oe = 1'b1;
							d.rd     = q.sh[SMR_RW_POS];
							d.space  = q.sh[7:SMR_ID_POS] ==
								SMR_ID_CLOCK;
							d.dst    = D_ACK;
						end else begin
							d.dst = D_IDLE;
						end
					end else if (q.wa_n != SMR_WADDR_BYTES) begin
						d.wa     = {q.wa[7:0], q.sh};
						d.wa_n   = q.wa_n + 2'h1;
						d.sda_oe = 1'b1;
						d.dst    = D_ACK;
					end else begin
						// Write data is not taken by this engine
						d.dst = D_IDLE;
					end
				end
			end
			D_ACK: begin
				if (fall) begin
					if (q.rd) begin
						load = 1'b1;
					end else begin
						d.sda_oe = 1'b0;
						d.dst    = D_WADDR;
					end
				end
			end
			D_TX: begin
				if (fall) begin
					if (q.cnt == SMR_LAST_BIT) begin
						d.sda_oe = 1'b0;
						d.dst    = D_RACK;
					end else begin
						d.sh     = {q.sh[6:0], 1'b0};
						d.sda_oe = !q.sh[6];
						d.cnt    = q.cnt + 3'h1;
					end
				end
			end
			D_RACK: begin
				if (rise) begin
					d.mack = !q.sda_s;
				end
				if (fall) begin
					if (q.mack) begin
						load = 1'b1;
					end else begin
						d.dst = D_IDLE;
					end
				end
			end
			default: begin
				d.dst = D_IDLE;
			end
			endcase
		end
		if (load) begin
			// Fetch byte at counter, then step past it
			d.sh     = mem_rdata;
			d.sda_oe = !mem_rdata[7];
			d.addr   = q.addr + SMR_ADDR_STEP;
			d.cnt    = '0;
			d.dst    = D_TX;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q       <= '0;
			q.addr  <= SMR_ADDR_RST;
			// Bus idles high, so no false edge after reset
			q.scl_m <= 1'b1;
			q.scl_s <= 1'b1;
			q.scl_p <= 1'b1;
			q.sda_m <= 1'b1;
			q.sda_s <= 1'b1;
			q.sda_p <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = q.sda_oe;
	assign mem_addr        = q.addr;
	assign mem_space       = q.space;
	assign busy            = q.dst != D_IDLE;
endmodule // smr_dev

// ---- hdl/smr_host.sv ----
`timescale 1ns/1ns
module smr_host
	import smr_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// Serial link
	smr_if.host              link,
	// Command
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire smr_cmd_e    cmd_kind,
	input  wire logic        cmd_space,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [7:0]  cmd_len,
	// Read data
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [7:0]       rd_data,
	// Status
	output logic             busy,
	output logic             nack_err
);
	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} smr_hst_e;

	typedef enum logic [2:0] {
		OP_S,
		OP_WIDW,
		OP_WIDR,
		OP_WAH,
		OP_WAL,
		OP_RD,
		OP_P
	} smr_op_e;

	typedef struct packed {
		logic        sda_m;
		logic        sda_s;
		smr_hst_e    hst;
		logic [2:0]  div;
		logic [1:0]  ph;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic        rx;
		logic [2:0]  step;
		smr_cmd_e    kind;
		logic        space;
		logic [15:0] addr;
		logic [7:0]  left;
		logic        scl_oe;
		logic        sda_oe;
		logic        err;
	} smr_host_s;

	// Order of bus operations for each command
	function automatic smr_op_e op_at(input smr_cmd_e k,
		input logic [2:0] s);
		op_at = OP_P;
		unique case (k)
		SMR_CUR_READ: begin
			unique case (s)
			3'h0: op_at = OP_S;
			3'h1: op_at = OP_WIDR;
			3'h2: op_at = OP_RD;
			default: op_at = OP_P;
			endcase
		end
		SMR_RAND_READ: begin
			unique case (s)
			3'h0, 3'h4: op_at = OP_S;
			3'h1: op_at = OP_WIDW;
			3'h2: op_at = OP_WAH;
			3'h3: op_at = OP_WAL;
			3'h5: op_at = OP_WIDR;
			3'h6: op_at = OP_RD;
			default: op_at = OP_P;
			endcase
		end
		SMR_SET_ADDR: begin
			unique case (s)
			3'h0: op_at = OP_S;
			3'h1: op_at = OP_WIDW;
			3'h2: op_at = OP_WAH;
			3'h3: op_at = OP_WAL;
			default: op_at = OP_P;
			endcase
		end
		default: op_at = OP_P;
		endcase
	endfunction

	smr_host_s  q;
	smr_host_s  d;
	logic       tick;
	logic       go;
	logic       push;
	logic       fifo_ready;
	logic [2:0] gstep;

	assign tick = q.div == 3'h0;

	always_comb begin
		d = q;
		go = 1'b0;
		push = 1'b0;
		gstep = q.step + 3'h1;
		d.sda_m = link.sda;
		d.sda_s = q.sda_m;
		d.div = tick ? SMR_SCL_HALF_CYC - 3'h1 : q.div - 3'h1;
		unique case (q.hst)
		H_IDLE: begin
			if (cmd_valid) begin
				d.kind  = cmd_kind;
				d.space = cmd_space;
				d.addr  = cmd_addr;
				d.left  = cmd_len == 8'h00 ? 8'h01 : cmd_len;
				d.err   = 1'b0;
				d.step  = 3'h0;
				d.ph    = 2'h0;
				d.hst   = H_START;
			end
		end
		H_START: begin
			if (tick) begin
				d.ph = q.ph + 2'h1;
				unique case (q.ph)
				2'h0: d.sda_oe = 1'b0;
				2'h1: d.scl_oe = 1'b0;
				2'h2: d.sda_oe = 1'b1;
				2'h3: begin
					d.scl_oe = 1'b1;
					go = 1'b1;
				end
				endcase
			end
		end
		H_BIT: begin
			// Data settles a full tick before the clock rises
			if (tick && q.ph == 2'h0) begin
				if (!(q.bitn == SMR_ACK_BIT && q.rx && !fifo_ready)) begin
					if (q.bitn != SMR_ACK_BIT) begin
						d.sda_oe = !q.rx && !q.sh[7];
					end else begin
						d.sda_oe = q.rx && q.left != 8'h01;
						push = q.rx;
					end
					d.ph = 2'h2;
				end
			end else if (tick && q.ph == 2'h2) begin
				d.scl_oe = 1'b0;
				d.ph = 2'h1;
			end else if (tick) begin
				d.scl_oe = 1'b1;
				d.ph = 2'h0;
				if (q.bitn != SMR_ACK_BIT) begin
					d.sh = {q.sh[6:0], q.rx ? q.sda_s : 1'b0};
					d.bitn = q.bitn + 4'h1;
				end else if (q.rx) begin
					if (q.left != 8'h01) begin
						d.left = q.left - 8'h01;
						d.bitn = 4'h0;
					end else begin
						go = 1'b1;
					end
				end else if (q.sda_s) begin
					d.err = 1'b1;
					d.hst = H_STOP;
				end else begin
					go = 1'b1;
				end
			end
		end
		H_STOP: begin
			if (tick) begin
				d.ph = q.ph + 2'h1;
				unique case (q.ph)
				2'h0: d.sda_oe = 1'b1;
				2'h1: d.scl_oe = 1'b0;
				default: begin
					d.sda_oe = 1'b0;
					d.hst = H_IDLE;
				end
				endcase
			end
		end
		endcase
		if (go) begin
			d.step = gstep;
			d.ph = 2'h0;
			d.bitn = 4'h0;
			d.hst = H_BIT;
			d.rx = 1'b0;
			unique case (op_at(q.kind, gstep))
			OP_S: d.hst = H_START;
			OP_P: d.hst = H_STOP;
			OP_WIDW: d.sh = smr_slave_byte(q.space, 1'b0);
			OP_WIDR: d.sh = smr_slave_byte(q.space, 1'b1);
			OP_WAH: d.sh = q.addr[15:8];
			OP_WAL: d.sh = q.addr[7:0];
			OP_RD: d.rx = 1'b1;
			default: d.hst = H_STOP;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	smr_fifo #(
		.W(SMR_FIFO_W),
		.D(SMR_FIFO_D)
	) smr_fifo_inst (
		.clock     (clock),
		.reset_n   (reset_n),
		.ce        (ce),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (q.sh),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = q.scl_oe;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = q.sda_oe;
	assign cmd_ready        = q.hst == H_IDLE;
	assign busy             = q.hst != H_IDLE;
	assign nack_err         = q.err;
endmodule // smr_host

// ---- tb/smr_assertions.sv ----
`timescale 1ns/1ns
module smr_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Serial link
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ------------------------------
	// Bit tracker
	// ------------------------------
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic       first_q;
	logic       rd_q;
	logic       nack_q;
	wire        rise  = scl && !scl_q;
	wire        start = scl && scl_q && !sda && sda_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_q <= 4'h0;
			first_q <= 1'b0;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				bit_q <= 4'h0;
				first_q <= 1'b1;
				nack_q <= 1'b0;
			end else if (rise) begin
				bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
				if (bit_q == 4'h9) first_q <= 1'b0;
				if (first_q && bit_q == 4'h7) rd_q <= sda;
				if (bit_q == 4'h8) nack_q <= sda;
			end
		end
	end

	// ------------------------------
	// Checks
	// ------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_slave_ack: assert property (
		rise && first_q && bit_q == 4'h8 |-> dev_sda_oe && !sda)
		else $error("slave byte not acknowledged");
	a_addr_ack: assert property (
		rise && !first_q && !rd_q && bit_q == 4'h8 |-> dev_sda_oe)
		else $error("address byte not acknowledged");
	a_read_release: assert property (
		rise && !first_q && rd_q && bit_q == 4'h8 |-> !dev_sda_oe)
		else $error("data line held in ninth clock");
	a_host_quiet: assert property (
		rise && !first_q && rd_q && !nack_q && bit_q != 4'h8
		|-> !host_sda_oe)
		else $error("host drove data bit of read byte");
	a_dev_edge: assert property (
		$changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("device changed data line with clock high");
	a_stop_idle: assert property (
		scl && scl_q && sda && !sda_q |-> !dev_sda_oe [*8])
		else $error("device active after stop");
	a_host_edge: assert property (
		$changed(host_sda_oe) |-> !scl || ($past(scl) && $past(scl, 2)))
		else $error("host changed data line as clock rose");
	a_start_clean: assert property (
		start |-> host_sda_oe && !dev_sda_oe)
		else $error("start not made by host");
	a_start_clock: assert property (
		start |-> ##[1:8] !scl)
		else $error("no clock after start");
endmodule // smr_assertions

// ---- tb/smr_tb.sv ----
`timescale 1ns/1ns
module smr_tb;
	import smr_pkg::*;
	// ------------------------------
	// Signals
	// ------------------------------
	logic        clock;
	logic        reset_n;
	logic        cmd_valid;
	logic        cmd_ready;
	smr_cmd_e    cmd_kind;
	logic        cmd_space;
	logic [15:0] cmd_addr;
	logic [7:0]  cmd_len;
	logic        rd_valid;
	logic        rd_ready;
	logic [7:0]  rd_data;
	logic        host_busy;
	logic        nack_err;
	logic [15:0] mem_addr;
	logic        mem_space;
	logic        dev_busy;
	int          bad_count;
	int          tests_run;

	function automatic logic [7:0] mem_f(input logic s,
		input logic [15:0] a);
		mem_f = a[7:0] ^ a[15:8] ^ {s, 7'h00} ^ 8'h5A;
	endfunction

	wire logic [7:0] mem_rdata = mem_f(mem_space, mem_addr);

	// ------------------------------
	// Design and checker
	// ------------------------------
	smr_if smr_if_inst ();
	smr_host smr_host_inst (.clock(clock), .reset_n(reset_n), .ce(1'b1),
		.link(smr_if_inst.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_space(cmd_space),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .busy(host_busy),
		.nack_err(nack_err));
	smr_dev smr_dev_inst (.clock(clock), .reset_n(reset_n), .ce(1'b1),
		.link(smr_if_inst.dev), .mem_addr(mem_addr),
		.mem_space(mem_space), .mem_rdata(mem_rdata), .busy(dev_busy));
	smr_assertions smr_assertions_inst (.clock(clock), .reset_n(reset_n),
		.host_sda_oe(smr_if_inst.host_sda_oe),
		.dev_sda_oe(smr_if_inst.dev_sda_oe), .scl(smr_if_inst.scl),
		.sda(smr_if_inst.sda));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tmo(input int w);
		if (w >= 4000) begin
			bad_count++;
			$display("ERROR %0t ns: wait limit reached", $time);
			results();
		end
	endtask

	task automatic run(input smr_cmd_e k, input logic s,
		input logic [15:0] a, input logic [7:0] n, input int stall);
		int w;
		w = 0;
		while (cmd_ready !== 1'b1 && w < 4000) begin
			@(negedge clock);
			w++;
		end
		tmo(w);
		cmd_kind = k;
		cmd_space = s;
		cmd_addr = a;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		repeat (stall) @(negedge clock);
		for (int i = 0; i < n; i++) begin
			w = 0;
			while (rd_valid !== 1'b1 && w < 4000) begin
				@(negedge clock);
				w++;
			end
			tmo(w);
			chk_val({8'h00, rd_data}, {8'h00, mem_f(s, a + 16'(i))});
			rd_ready = 1'b1;
			@(negedge clock);
			rd_ready = 1'b0;
		end
		w = 0;
		while ((host_busy !== 1'b0 || dev_busy !== 1'b0) && w < 4000) begin
			@(negedge clock);
			w++;
		end
		tmo(w);
		chk_val(mem_addr, a + 16'(n));
		chk_val({15'h0000, nack_err}, 16'h0000);
		chk_val({15'h0000, mem_space}, {15'h0000, s});
		chk_val({15'h0000, rd_valid}, 16'h0000);
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_first;
		chk_val(mem_addr, 16'h0000);
		run(SMR_CUR_READ, 1'b0, 16'h0000, 8'h02, 0);
		$display("test first read done");
	endtask

	task automatic t_random;
		run(SMR_RAND_READ, 1'b1, 16'h1234, 8'h03, 0);
		run(SMR_CUR_READ, 1'b1, 16'h1237, 8'h01, 0);
		$display("test random read done");
	endtask

	task automatic t_set;
		run(SMR_SET_ADDR, 1'b0, 16'h00FF, 8'h00, 0);
		run(SMR_CUR_READ, 1'b0, 16'h00FF, 8'h02, 0);
		$display("test set address done");
	endtask

	task automatic t_wrap;
		run(SMR_RAND_READ, 1'b0, 16'hFFFD, 8'h0C, 2000);
		$display("test wrap and stall done");
	endtask

	task automatic results;
		$display("tests_run %0d bad_count %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = SMR_CUR_READ;
		cmd_space = 1'b0;
		cmd_addr = 16'h0000;
		cmd_len = 8'h00;
		rd_ready = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (4) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		t_first();
		t_random();
		t_set();
		t_wrap();
		results();
	end
endmodule // smr_tb
